// [hif_irq_ctrl.sv]
`timescale 1ns/10ps
`default_nettype none
`include "hif_defs.svh"

// Notes on behaviour
// [R1] First masked status: eight events, six of them data-ready
// [R2] Second masked status: copy, standard, FIFO full
// [R3] FIFO full means a write was refused
// [R4] Interrupt output ORs all unmasked flags
// [R5] Mask gates both status and interrupt
// [R6] First mask bits enable sources, reset zero
// [R7] Second mask bits 1,0 enable, reset zero
// [R8] Second mask bit 2 gates copy change
// [R9] Write one clears first flags; zero ignored
// [R10] Write one clears second raw/masked flags
// [R11] Interrupt drops once no unmasked flag remains
// [R12] Masked equals raw AND mask; raw unmasked
// [R13] Reads never clear flags
// [R14] FIFO full set when line cannot fit
// [R15] Event beats a simultaneous clear
// [R16] Interrupt active high, registered one clock
module hif_irq_ctrl (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic ce,
	input wire hif_pkg::hif_events_lo_t eventsLo,
	input wire hif_pkg::hif_events_hi_t eventsHi,
	input wire hif_pkg::hif_host_req_t hostReq,
	output logic [7:0] regRdata,
	output logic irqOut
);

	logic [`HIF_LO_W-1:0] rawLo;
	logic [`HIF_HI_W-1:0] rawHi;
	logic [`HIF_LO_W-1:0] maskLo;
	logic [`HIF_HI_W-1:0] maskHi;
	logic [`HIF_LO_W-1:0] maskedLo;
	logic [`HIF_HI_W-1:0] maskedHi;
	logic [`HIF_LO_W-1:0] clrLo;
	logic [`HIF_HI_W-1:0] clrHi;
	logic [`HIF_LO_W-1:0] evLo;
	logic [`HIF_HI_W-1:0] evHi;
	logic [`HIF_LO_W-1:0] next_maskLo;
	logic [`HIF_HI_W-1:0] next_maskHi;
	logic [7:0] next_regRdata;
	logic next_irqOut;

	function automatic logic hit(input hif_pkg::hif_host_req_t r,
		input logic [7:0] a);
		hit = r.wr && (r.addr == a);
	endfunction : hit

	assign evLo = eventsLo; // see [R1]
	// Refused FIFO line write, not a FIFO level
	assign evHi = eventsHi; // see [R2] see [R3] see [R14]

	// Write-one clear pulses
	assign clrLo = hit(hostReq, `HIF_ADDR_CLR_LO) ?
		hostReq.wdata : 8'h00; // see [R9]
	assign clrHi = hit(hostReq, `HIF_ADDR_CLR_HI) ?
		hostReq.wdata[`HIF_HI_W-1:0] : 3'h0; // see [R10]

	hif_flag_bank #(.WIDTH(`HIF_LO_W)) u_bank_lo (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.ce(ce),
		.setPulse(evLo),
		.clrPulse(clrLo),
		.flags(rawLo)
	);

	hif_flag_bank #(.WIDTH(`HIF_HI_W)) u_bank_hi (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.ce(ce),
		.setPulse(evHi),
		.clrPulse(clrHi),
		.flags(rawHi)
	);

	// Masked view
	assign maskedLo = rawLo & maskLo; // see [R12] see [R5]
	assign maskedHi = rawHi & maskHi; // see [R12] see [R8]

	// Mask registers
	always_comb begin
		next_maskLo = maskLo;
		next_maskHi = maskHi;
		if (ce && hit(hostReq, `HIF_ADDR_MASK_LO)) begin
			next_maskLo = hostReq.wdata; // see [R6]
		end
		if (ce && hit(hostReq, `HIF_ADDR_MASK_HI)) begin
			next_maskHi = hostReq.wdata[`HIF_HI_W-1:0]; // see [R7] see [R8]
		end
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			maskLo <= `HIF_RST_MASK_LO;
			maskHi <= `HIF_RST_MASK_HI;
		end else begin
			maskLo <= next_maskLo;
			maskHi <= next_maskHi;
		end
	end

	// Read data and interrupt output
	always_comb begin
		next_regRdata = regRdata;
		next_irqOut = irqOut;
		if (ce) begin
			next_irqOut = (|maskedLo) | (|maskedHi); // see [R4] see [R11] see [R16]
			if (hostReq.rd) begin
				// Reads have no side effect on flags
				unique case (hostReq.addr) // see [R13]
					`HIF_ADDR_RAW_LO: next_regRdata = rawLo;
					`HIF_ADDR_RAW_HI: next_regRdata = {5'h00, rawHi};
					`HIF_ADDR_STAT_LO: next_regRdata = maskedLo;
					`HIF_ADDR_STAT_HI: next_regRdata = {5'h00, maskedHi};
					`HIF_ADDR_MASK_LO: next_regRdata = maskLo;
					`HIF_ADDR_MASK_HI: next_regRdata = {5'h00, maskHi};
					default: next_regRdata = 8'h00;
				endcase
			end
		end
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			regRdata <= `HIF_RST_RDATA;
			irqOut <= 1'b0;
		end else begin
			regRdata <= next_regRdata;
			irqOut <= next_irqOut;
		end
	end

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (sys_rst);

	sequence s_all_masked;
		(ce && maskLo == 8'h00 && maskHi == 3'h0) [*2];
	endsequence

	sequence s_read_masked_lo;
		ce && hostReq.rd && hostReq.addr == `HIF_ADDR_STAT_LO;
	endsequence

	a_masked_read_lo: assert property (s_read_masked_lo |=>
		regRdata == $past(rawLo & maskLo)) // see [R12]
		else $error("masked status read differs from raw and mask");

	a_hi_reserved_zero: assert property (ce && hostReq.rd &&
		hostReq.addr == `HIF_ADDR_STAT_HI |=> regRdata[7:3] == 5'h00) // see [R2]
		else $error("reserved status bits not zero");

	a_irq_follows: assert property (ce |=>
		irqOut == $past((|(rawLo & maskLo)) | (|(rawHi & maskHi)))) // see [R4]
		else $error("interrupt output does not follow masked flags");

	a_masked_no_irq: assert property (s_all_masked |-> !irqOut) // see [R5]
		else $error("interrupt asserted with all sources masked");

	a_clear_lo_works: assert property (ce &&
		hit(hostReq, `HIF_ADDR_CLR_LO) && (evLo & hostReq.wdata) == 8'h00
		|=> (rawLo & $past(hostReq.wdata)) == 8'h00) // see [R9]
		else $error("first clear write did not clear flags");

	a_clear_hi_works: assert property (ce &&
		hit(hostReq, `HIF_ADDR_CLR_HI) &&
		(evHi & hostReq.wdata[2:0]) == 3'h0
		|=> (rawHi & $past(hostReq.wdata[2:0])) == 3'h0 &&
		(maskedHi & $past(hostReq.wdata[2:0])) == 3'h0) // see [R10]
		else $error("second clear write did not clear flags");

	a_set_wins: assert property (ce && evLo != 8'h00 |=>
		(rawLo & $past(evLo)) == $past(evLo)) // see [R15]
		else $error("event lost against clear");

	a_set_wins_hi: assert property (ce && evHi != 3'h0 |=>
		(rawHi & $past(evHi)) == $past(evHi)) // see [R15]
		else $error("second group event lost against clear");

	a_read_keeps: assert property (ce && hostReq.rd && !hostReq.wr |=>
		(rawLo & $past(rawLo)) == $past(rawLo) &&
		(rawHi & $past(rawHi)) == $past(rawHi)) // see [R13]
		else $error("read cleared a flag");

	a_mask_write: assert property (ce &&
		hit(hostReq, `HIF_ADDR_MASK_LO) |=> maskLo == $past(hostReq.wdata)) // see [R6]
		else $error("mask register not written");

	a_fifo_full_set: assert property (ce && eventsHi.fifoLineRejected |=>
		rawHi[`HIF_HI_FIFO_FULL]) // see [R3]
		else $error("refused FIFO line did not set full flag");

endmodule : hif_irq_ctrl

`default_nettype wire

// [hif_defs.svh]
`ifndef HIF_DEFS_SVH
`define HIF_DEFS_SVH

// Register subaddresses
`define HIF_ADDR_RAW_LO 8'hf0
`define HIF_ADDR_RAW_HI 8'hf1
`define HIF_ADDR_STAT_LO 8'hf2
`define HIF_ADDR_STAT_HI 8'hf3
`define HIF_ADDR_MASK_LO 8'hf4
`define HIF_ADDR_MASK_HI 8'hf5
`define HIF_ADDR_CLR_LO 8'hf6
`define HIF_ADDR_CLR_HI 8'hf7

// Field widths and positions
`define HIF_LO_W 8
`define HIF_HI_W 3
`define HIF_HI_FIFO_FULL 0
`define HIF_HI_STD_CHANGED 1
`define HIF_HI_COPY_CHANGED 2

// Reset values
`define HIF_RST_MASK_LO 8'h00
`define HIF_RST_MASK_HI 3'h0
`define HIF_RST_FLAGS_LO 8'h00
`define HIF_RST_FLAGS_HI 3'h0
`define HIF_RST_RDATA 8'h00

`endif

// [hif_pkg.sv]
package hif_pkg;

	// Event pulses, first group, bit 7 down to bit 0
	typedef struct packed {
		logic fifoLevelCrossedEvent;
		logic teletextReadyFlag;
		logic wssReady;
		logic programIdReadyFlag;
		logic vitcReady;
		logic captionField2Ready;
		logic captionField1Ready;
		logic lineEvent;
	} hif_events_lo_t;

	// Event pulses, second group, bit 2 down to bit 0
	typedef struct packed {
		logic copyProtChanged;
		logic standardChanged;
		logic fifoLineRejected;
	} hif_events_hi_t;

	// Host register access at a subaddress
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} hif_host_req_t;

endpackage : hif_pkg

// [hif_flag_bank.sv]
`timescale 1ns/10ps
`default_nettype none

module hif_flag_bank #(
	parameter int WIDTH = 8
) (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic ce,
	input wire logic [WIDTH-1:0] setPulse,
	input wire logic [WIDTH-1:0] clrPulse,
	output logic [WIDTH-1:0] flags
);

	// Elaboration-time width check
	if (WIDTH < 1 || WIDTH > 8) begin : g_bad_width
		$error("hif_flag_bank: WIDTH must be 1 to 8");
	end

	logic [WIDTH-1:0] next_flags;

	// Sticky flags, cleared only by explicit clear pulses or reset
	always_comb begin
		next_flags = flags;
		if (ce) begin
			next_flags = (flags & ~clrPulse) | setPulse; // see [R15]
		end
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			flags <= '0;
		end else begin
			flags <= next_flags;
		end
	end

endmodule : hif_flag_bank

`default_nettype wire

// [hif_host_model.sv]
`timescale 1ns/10ps
`default_nettype none

module hif_host_model (
	input wire logic wrCmd,
	input wire logic rdCmd,
	input wire logic [7:0] addrCmd,
	input wire logic [7:0] dataCmd,
	output var hif_pkg::hif_host_req_t hostReq
);
	// One byte access a cycle, write one to clear
	assign hostReq = '{wrCmd, rdCmd, addrCmd, dataCmd};
endmodule : hif_host_model

`default_nettype wire

// [test_host_interrupt_flag_logic.sv]
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, a) begin compares++; if ((a) !== (e)) begin \
bad_count++; $display("[FAIL] %s expected %h seen %h", n, e, a); end end

module test_host_interrupt_flag_logic;
	logic mclk = 0;
	logic sysRst = 1;
	logic ceIn = 1;
	logic wrCmd = 0;
	logic rdCmd = 0;
	logic [7:0] addrCmd = 8'h00;
	logic [7:0] dataCmd = 8'h00;
	logic [7:0] regRdata;
	logic irqOut;
	hif_pkg::hif_events_lo_t evLo = 8'h00;
	hif_pkg::hif_events_hi_t evHi = 3'h0;
	hif_pkg::hif_host_req_t hostReq;
	int bad_count = 0;
	int compares = 0;
	int cyc = 0;

	always #10 mclk = ~mclk;

	hif_host_model host (.wrCmd(wrCmd), .rdCmd(rdCmd), .addrCmd(addrCmd),
		.dataCmd(dataCmd), .hostReq(hostReq));
	hif_irq_ctrl uut (.mclk(mclk), .sys_rst(sysRst), .ce(ceIn),
		.eventsLo(evLo), .eventsHi(evHi), .hostReq(hostReq),
		.regRdata(regRdata), .irqOut(irqOut));

	task automatic step;
		@(posedge mclk);
		#1;
	endtask : step

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		wrCmd = 1;
		addrCmd = a;
		dataCmd = d;
		step();
		wrCmd = 0;
		// Idle cycle between accesses
		step();
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		rdCmd = 1;
		addrCmd = a;
		step();
		rdCmd = 0;
		step();
		`CHK("rdata", e, regRdata)
	endtask : rd

	// Write with events in the same cycle
	task automatic clash(input logic [7:0] a, input logic [7:0] d,
		input logic [7:0] l, input logic [2:0] h);
		evLo = l;
		evHi = h;
		wrCmd = 1;
		addrCmd = a;
		dataCmd = d;
		step();
		evLo = 8'h00;
		evHi = 3'h0;
		wrCmd = 0;
		step();
	endtask : clash

	task automatic irq(input logic e);
		`CHK("irqOut", e, irqOut)
	endtask : irq

	task automatic stop_test;
		$display("compares %0d mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : stop_test

	always @(posedge mclk) begin
		cyc++;
		if (cyc == 5000) begin
			bad_count++;
			stop_test();
		end
	end

	initial begin
		repeat (16) @(posedge mclk);
		#1;
		sysRst = 0;
		rd(8'hf4, 8'h00);
		rd(8'hf5, 8'h00);
		irq(1'b0);
		$display("reset test done");
		evLo = 8'hff;
		evHi = 3'h7;
		step();
		evLo = 8'h00;
		evHi = 3'h0;
		rd(8'hf0, 8'hff);
		rd(8'hf0, 8'hff);
		rd(8'hf1, 8'h07);
		rd(8'hf2, 8'h00);
		rd(8'hf3, 8'h00);
		irq(1'b0);
		$display("raw test done");
		for (int i = 0; i < 8; i++) begin
			wr(8'hf4, 8'h01 << i);
			rd(8'hf2, 8'h01 << i);
			irq(1'b1);
		end
		wr(8'hf4, 8'h00);
		for (int i = 0; i < 3; i++) begin
			wr(8'hf5, 8'h01 << i);
			rd(8'hf3, 8'h01 << i);
			irq(1'b1);
		end
		$display("mask test done");
		wr(8'hf5, 8'h00);
		wr(8'hf4, 8'h01);
		wr(8'hf6, 8'hfe);
		rd(8'hf0, 8'h01);
		irq(1'b1);
		wr(8'hf6, 8'h00);
		rd(8'hf0, 8'h01);
		wr(8'hf6, 8'h01);
		irq(1'b0);
		rd(8'hf0, 8'h00);
		evLo = 8'h01;
		step();
		evLo = 8'h00;
		irq(1'b0);
		step();
		irq(1'b1);
		wr(8'hf6, 8'h01);
		irq(1'b0);
		wr(8'hf5, 8'h07);
		rd(8'hf3, 8'h07);
		wr(8'hf7, 8'h05);
		rd(8'hf1, 8'h02);
		rd(8'hf3, 8'h02);
		irq(1'b1);
		wr(8'hf7, 8'h02);
		rd(8'hf1, 8'h00);
		rd(8'hf3, 8'h00);
		irq(1'b0);
		$display("clear test done");
		clash(8'hf6, 8'h01, 8'h01, 3'h0);
		rd(8'hf0, 8'h01);
		clash(8'hf7, 8'h02, 8'h00, 3'h2);
		rd(8'hf1, 8'h02);
		wr(8'hf0, 8'hff);
		rd(8'hf0, 8'h01);
		wr(8'hf6, 8'h01);
		wr(8'hf7, 8'h02);
		rd(8'hf0, 8'h00);
		rd(8'hf1, 8'h00);
		rd(8'h10, 8'h00);
		$display("collision test done");
		ceIn = 0;
		clash(8'hf4, 8'hff, 8'h02, 3'h1);
		ceIn = 1;
		rd(8'hf4, 8'h01);
		rd(8'hf0, 8'h00);
		rd(8'hf1, 8'h00);
		$display("enable test done");
		evHi = 3'h4;
		step();
		evHi = 3'h0;
		sysRst = 1;
		step();
		step();
		sysRst = 0;
		rd(8'hf1, 8'h00);
		rd(8'hf4, 8'h00);
		irq(1'b0);
		$display("second reset test done");
		stop_test();
	end
endmodule : test_host_interrupt_flag_logic

`default_nettype wire
